// file: shared/nps_pkg.sv
// constants and types for the network port status and strap block
package nps_pkg;

    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned STRETCH_MS      = 50;
    localparam int unsigned STRETCH_CYCLES  = (CLK_HZ / 1000) * STRETCH_MS;

    localparam int unsigned POL_LINK_PULSES = 7;
    localparam int unsigned POL_PACKETS     = 3;
    localparam int unsigned LINK_CNT_W      = 3;
    localparam int unsigned PKT_CNT_W       = 2;

    localparam int unsigned WB_ADR_W        = 4;
    localparam int unsigned WB_DAT_W        = 32;
    localparam int unsigned WB_SEL_W        = 4;
    localparam int unsigned DUAL_PINS       = 5;

    localparam logic [WB_ADR_W-1:0] CTRL_OFS   = 4'h0;
    localparam logic [WB_ADR_W-1:0] STATUS_OFS = 4'h4;

    localparam logic [WB_DAT_W-1:0] CTRL_RST   = 32'h00000000;

    // control register fields
    localparam int unsigned CTRL_LAMP_BIT   = 0;

    // status register fields
    localparam int unsigned ST_EXT_BIT      = 0;
    localparam int unsigned ST_AUI_BIT      = 1;
    localparam int unsigned ST_LTEN_BIT     = 2;
    localparam int unsigned ST_LSQ_BIT      = 3;
    localparam int unsigned ST_LINK_BIT     = 4;
    localparam int unsigned ST_POL_BIT      = 5;
    localparam int unsigned ST_TX_BIT       = 6;
    localparam int unsigned ST_RX_BIT       = 7;
    localparam int unsigned ST_COL_BIT      = 8;

    // dual-role pin order
    localparam int unsigned PIN_CRS         = 0;
    localparam int unsigned PIN_COL         = 1;
    localparam int unsigned PIN_RXD         = 2;
    localparam int unsigned PIN_RXC         = 3;
    localparam int unsigned PIN_TXC         = 4;

    typedef struct packed {
        logic                      captured;
        logic                      extSel;
        logic                      auiSel;
        logic                      linkTestEn;
        logic                      lowSquelch;
        logic                      lampTest;
        logic                      polFault;
        logic [LINK_CNT_W-1:0]     linkRevCnt;
        logic [PKT_CNT_W-1:0]      pktRevCnt;
        logic                      linkN;
        logic                      polN;
        logic                      ack;
        logic [WB_DAT_W-1:0]       rdata;
    } nps_state_t;

endpackage

// file: hdl/nps_stretch.sv
// retriggerable activity stretcher driving one active-low indicator
`timescale 1ns/1ps
module nps_stretch
    import nps_pkg::*;
#(
    parameter int unsigned CYCLES = STRETCH_CYCLES
)
(
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic trigger,
    input  wire logic forceOn,
    output logic      active,
    output logic      indicatorN
);

    localparam int unsigned CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);
    localparam logic [CNT_W-1:0] ZERO = '0;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             busy;
        logic             ledN;
    } nps_stretch_state_t;

    nps_stretch_state_t state_r;
    nps_stretch_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        if (trigger)
        begin
            // each event reloads the full interval
            state_nxt.count = LOAD;
            state_nxt.busy  = 1'b1;
        end
        else if (state_r.count != ZERO)
        begin
            state_nxt.count = state_r.count - 1'b1;
        end
        else
        begin
            state_nxt.busy = 1'b0;
        end
        state_nxt.ledN = ~(state_nxt.busy | forceOn);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_r.count <= ZERO;
            state_r.busy  <= 1'b0;
            state_r.ledN  <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign active     = state_r.busy;
    assign indicatorN = state_r.ledN;

endmodule

// file: hdl/nps_port_status.sv
// network port strap decoding, pin role steering and status indicators
//
// Functional notes
// - external codec select high turns the internal codec off, low on.
// - dual-role pins drive their first function when internal, else in.
// - attachment select high routes the codec to AUI, low to pair module.
// - transmit indicator goes low for about 50 ms on each transmission.
// - receive indicator goes low for about 50 ms on received data.
// - collision indicator goes low for about 50 ms on each collision.
// - polarity indicator goes low after 7 reversed pulses or 3 packets.
// - link indicator is off in AUI mode or when enabled testing fails.
// - link indicator is on in pair mode with good link or test disabled.
// - link test disable strap low stops pulse generation and checking.
// - low squelch select high lowers the receive squelch threshold.
`timescale 1ns/1ps
module nps_port_status
    import nps_pkg::*;
#(
    parameter int unsigned STRETCH_LEN = STRETCH_CYCLES,
    parameter int unsigned NPINS       = DUAL_PINS
)
(
    input  wire logic                sys_clk,
    input  wire logic                rstn,

    // wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [WB_DAT_W-1:0] wb_dat_i,
    input  wire logic [WB_SEL_W-1:0] wb_sel_i,
    output logic      [WB_DAT_W-1:0] wb_dat_o,
    output logic                     wb_ack_o,

    // configuration straps
    input  wire logic                externalCodecSelect,
    input  wire logic                attachmentOrPairSelect,
    input  wire logic                linkTestDisableN,
    input  wire logic                lowSquelchSelect,

    // strap decode to the analog and codec sections
    output logic                     codecEnable,
    output logic                     auiPathEnable,
    output logic                     pairPathEnable,
    output logic                     linkPulseGenEnable,
    output logic                     linkCheckEnable,
    output logic                     squelchLowThreshold,

    // dual-role pins: crs, col, rxd, rxc, txc
    input  wire logic [NPINS-1:0]    dualPinIn,
    output logic      [NPINS-1:0]    dualPinOut,
    output logic      [NPINS-1:0]    dualPinOe,
    input  wire logic [NPINS-1:0]    codecSideSig,
    output logic      [NPINS-1:0]    macSideSig,

    // events from the mac and pair module
    input  wire logic                txActivity,
    input  wire logic                rxActivity,
    input  wire logic                collisionSeen,
    input  wire logic                linkPulseSeen,
    input  wire logic                linkPulseReversed,
    input  wire logic                packetEndSeen,
    input  wire logic                packetReversed,
    input  wire logic                linkIntegrityGood,

    // active-low indicators
    output logic                     txActivityIndicatorN,
    output logic                     rxActivityIndicatorN,
    output logic                     collisionIndicatorN,
    output logic                     polarityFaultIndicatorN,
    output logic                     linkGoodIndicatorN
);

    ////////////////////////////////////////////////////////////////////////
    // state

    localparam logic [LINK_CNT_W-1:0] LINK_LIMIT =
        LINK_CNT_W'(POL_LINK_PULSES);
    localparam logic [PKT_CNT_W-1:0]  PKT_LIMIT  =
        PKT_CNT_W'(POL_PACKETS);
    localparam logic [LINK_CNT_W-1:0] LINK_ZERO  = '0;
    localparam logic [PKT_CNT_W-1:0]  PKT_ZERO   = '0;
    localparam logic [WB_DAT_W-1:0]   DAT_ZERO   = '0;

    nps_state_t          state_r;
    nps_state_t          state_nxt;

    logic                txBusy;
    logic                rxBusy;
    logic                colBusy;
    logic                busReq;
    logic                busWrite;
    logic                ctrlHit;
    logic                statusHit;
    logic                polClearSw;
    logic                polClearHw;
    logic                linkRevHit;
    logic                pktRevHit;
    logic                linkOn;
    logic [WB_DAT_W-1:0] statusWord;
    logic [WB_DAT_W-1:0] ctrlWord;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    assign busReq    = wb_cyc_i & wb_stb_i & ~state_r.ack;
    assign busWrite  = busReq & wb_we_i;
    assign ctrlHit   = (wb_adr_i == CTRL_OFS);
    assign statusHit = (wb_adr_i == STATUS_OFS);

    // write one to the polarity bit of status clears the latched fault
    assign polClearSw = busWrite & statusHit & wb_sel_i[0]
                        & wb_dat_i[ST_POL_BIT];

    always_comb
    begin
        ctrlWord                = DAT_ZERO;
        ctrlWord[CTRL_LAMP_BIT] = state_r.lampTest;
    end

    always_comb
    begin
        statusWord              = DAT_ZERO;
        statusWord[ST_EXT_BIT]  = state_r.extSel;
        statusWord[ST_AUI_BIT]  = state_r.auiSel;
        statusWord[ST_LTEN_BIT] = state_r.linkTestEn;
        statusWord[ST_LSQ_BIT]  = state_r.lowSquelch;
        statusWord[ST_LINK_BIT] = ~state_r.linkN;
        statusWord[ST_POL_BIT]  = state_r.polFault;
        statusWord[ST_TX_BIT]   = txBusy;
        statusWord[ST_RX_BIT]   = rxBusy;
        statusWord[ST_COL_BIT]  = colBusy;
    end

    ////////////////////////////////////////////////////////////////////////
    // polarity detection

    assign linkRevHit = linkPulseSeen & linkPulseReversed;
    assign pktRevHit  = packetEndSeen & packetReversed;

    // a correctly polarity_fault_indicator pulse or packet shows the pair is wired right
    assign polClearHw = (linkPulseSeen & ~linkPulseReversed)
                        | (packetEndSeen & ~packetReversed);

    ////////////////////////////////////////////////////////////////////////
    // link indicator

    // AUI mode keeps the lamp dark even with testing disabled
    assign linkOn = ~state_r.auiSel
                    & (~state_r.linkTestEn | linkIntegrityGood);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        state_nxt = state_r;

        // straps are tied, sampled once after reset is released
        if (!state_r.captured)
        begin
            state_nxt.captured   = 1'b1;
            state_nxt.extSel     = externalCodecSelect;
            state_nxt.auiSel     = attachmentOrPairSelect;
            state_nxt.linkTestEn = linkTestDisableN;
            state_nxt.lowSquelch = lowSquelchSelect;
        end

        // consecutive reversed link pulses
        if (linkPulseSeen)
        begin
            if (!linkPulseReversed)
            begin
                state_nxt.linkRevCnt = LINK_ZERO;
            end
            else if (state_r.linkRevCnt != LINK_LIMIT)
            begin
                state_nxt.linkRevCnt = state_r.linkRevCnt + 1'b1;
            end
        end

        // consecutive reversed packets
        if (packetEndSeen)
        begin
            if (!packetReversed)
            begin
                state_nxt.pktRevCnt = PKT_ZERO;
            end
            else if (state_r.pktRevCnt != PKT_LIMIT)
            begin
                state_nxt.pktRevCnt = state_r.pktRevCnt + 1'b1;
            end
        end

        // clears first so that a detection in the same cycle wins
        if (polClearSw || polClearHw)
        begin
            state_nxt.polFault = 1'b0;
        end
        if ((linkRevHit && state_nxt.linkRevCnt == LINK_LIMIT)
            || (pktRevHit && state_nxt.pktRevCnt == PKT_LIMIT))
        begin
            state_nxt.polFault = 1'b1;
        end

        state_nxt.polN  = ~(state_nxt.polFault | state_r.lampTest);
        state_nxt.linkN = ~(linkOn | state_r.lampTest);

        // bus: one wait state, then ack for a single cycle
        state_nxt.ack = busReq;
        if (busReq)
        begin
            if (ctrlHit)
            begin
                state_nxt.rdata = ctrlWord;
            end
            else if (statusHit)
            begin
                state_nxt.rdata = statusWord;
            end
            else
            begin
                state_nxt.rdata = DAT_ZERO;
            end
        end

        if (busWrite && ctrlHit && wb_sel_i[0])
        begin
            state_nxt.lampTest = wb_dat_i[CTRL_LAMP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_r.captured   <= 1'b0;
            state_r.extSel     <= 1'b0;
            state_r.auiSel     <= 1'b0;
            state_r.linkTestEn <= 1'b1;
            state_r.lowSquelch <= 1'b0;
            state_r.lampTest   <= CTRL_RST[CTRL_LAMP_BIT];
            state_r.polFault   <= 1'b0;
            state_r.linkRevCnt <= LINK_ZERO;
            state_r.pktRevCnt  <= PKT_ZERO;
            state_r.linkN      <= 1'b1;
            state_r.polN       <= 1'b1;
            state_r.ack        <= 1'b0;
            state_r.rdata      <= DAT_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap decode outputs

    assign codecEnable         = ~state_r.extSel;
    assign auiPathEnable       = ~state_r.extSel & state_r.auiSel;
    assign pairPathEnable      = ~state_r.extSel & ~state_r.auiSel;
    assign linkPulseGenEnable  = pairPathEnable & state_r.linkTestEn;
    assign linkCheckEnable     = pairPathEnable & state_r.linkTestEn;
    assign squelchLowThreshold = state_r.lowSquelch;

    ////////////////////////////////////////////////////////////////////////
    // dual-role pins

    generate
        for (genvar i = 0; i < NPINS; i++)
        begin : g_pin
            // internal codec drives the pin, external codec drives us
            assign dualPinOut[i] = codecSideSig[i];
            assign dualPinOe[i]  = ~state_r.extSel;
            assign macSideSig[i] = state_r.extSel ? dualPinIn[i]
                                                  : codecSideSig[i];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // activity indicators

    nps_stretch #(
        .CYCLES     (STRETCH_LEN)
    ) u_tx_stretch (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .trigger    (txActivity),
        .forceOn    (state_r.lampTest),
        .active     (txBusy),
        .indicatorN (txActivityIndicatorN)
    );

    nps_stretch #(
        .CYCLES     (STRETCH_LEN)
    ) u_rx_stretch (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .trigger    (rxActivity),
        .forceOn    (state_r.lampTest),
        .active     (rxBusy),
        .indicatorN (rxActivityIndicatorN)
    );

    nps_stretch #(
        .CYCLES     (STRETCH_LEN)
    ) u_col_stretch (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .trigger    (collisionSeen),
        .forceOn    (state_r.lampTest),
        .active     (colBusy),
        .indicatorN (collisionIndicatorN)
    );

    ////////////////////////////////////////////////////////////////////////
    // remaining outputs

    assign polarityFaultIndicatorN = state_r.polN;
    assign linkGoodIndicatorN      = state_r.linkN;
    assign wb_ack_o                = state_r.ack;
    assign wb_dat_o                = state_r.rdata;

endmodule

// file: dv/nps_port_status_chk.sv
// concurrent checks on the port status block ports
`timescale 1ns/1ps
module nps_port_status_chk
    import nps_pkg::*;
#(
    parameter int unsigned STRETCH_LEN = STRETCH_CYCLES
)
(
    input wire logic                 sys_clk,
    input wire logic                 rstn,
    input wire logic                 codecEnable,
    input wire logic                 auiPathEnable,
    input wire logic                 pairPathEnable,
    input wire logic                 linkPulseGenEnable,
    input wire logic                 linkCheckEnable,
    input wire logic [DUAL_PINS-1:0] dualPinOe,
    input wire logic                 txActivity,
    input wire logic                 rxActivity,
    input wire logic                 collisionSeen,
    input wire logic                 linkPulseSeen,
    input wire logic                 linkPulseReversed,
    input wire logic                 packetEndSeen,
    input wire logic                 linkIntegrityGood,
    input wire logic                 txActivityIndicatorN,
    input wire logic                 rxActivityIndicatorN,
    input wire logic                 collisionIndicatorN,
    input wire logic                 polarityFaultIndicatorN,
    input wire logic                 linkGoodIndicatorN
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    logic [31:0] sinceTxR;
    logic        offW;
    logic        onW;
    assign offW = auiPathEnable || (linkCheckEnable && !linkIntegrityGood);
    assign onW = pairPathEnable && (!linkCheckEnable || linkIntegrityGood);

    // cycles since the last transmit trigger
    always_ff @(posedge sys_clk)
    begin
        if (!rstn || txActivity)
            sinceTxR <= 32'h0;
        else
            sinceTxR <= sinceTxR + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    AST_OE: assert property (dualPinOe == {DUAL_PINS{codecEnable}})
        else $error("dual pin enables disagree with codec select");
    AST_PATH: assert property (
        (auiPathEnable || pairPathEnable) == codecEnable
        && !(auiPathEnable && pairPathEnable))
        else $error("path enables inconsistent");
    AST_LINKEN: assert property (
        linkPulseGenEnable == linkCheckEnable
        && (!linkCheckEnable || pairPathEnable))
        else $error("link test enables inconsistent");
    AST_TXON: assert property (txActivity |=> !txActivityIndicatorN)
        else $error("tx indicator not low after activity");
    AST_RXON: assert property (rxActivity |=> !rxActivityIndicatorN)
        else $error("rx indicator not low after activity");
    AST_COLON: assert property (collisionSeen |=> !collisionIndicatorN)
        else $error("collision indicator not low after collision");
    AST_TXHOLD: assert property (
        $rose(txActivityIndicatorN) |-> sinceTxR >= STRETCH_LEN - 2)
        else $error("tx indicator released before stretch ran out");
    AST_LINKOFF: assert property (
        offW && $past(offW) |-> linkGoodIndicatorN)
        else $error("link indicator on while it should be off");
    // the lamp lags the strap registers, so skip the edge after reset
    AST_LINKON: assert property (
        onW && $past(onW) && $past(rstn) |-> !linkGoodIndicatorN)
        else $error("link indicator off while it should be on");
    AST_POLCLR: assert property (
        linkPulseSeen && !linkPulseReversed && !packetEndSeen
        |-> ##2 polarityFaultIndicatorN)
        else $error("polarity indicator stays on after good pulse");

    cover property (txActivity ##[1:20] txActivity);
    cover property ($fell(polarityFaultIndicatorN));
    cover property ($fell(linkGoodIndicatorN) && pairPathEnable);
endmodule

// file: dv/nps_board_model.sv
// board model: strap pins and far side of the dual-role pins
`timescale 1ns/1ps
module nps_board_model
    import nps_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic [3:0]           strapCfg,
    input  wire logic [DUAL_PINS-1:0] dualPinOut,
    input  wire logic [DUAL_PINS-1:0] dualPinOe,
    output logic      [DUAL_PINS-1:0] dualPinIn,
    output logic                      externalCodecSelect,
    output logic                      attachmentOrPairSelect,
    output logic                      linkTestDisableN,
    output logic                      lowSquelchSelect
);
    logic [DUAL_PINS-1:0] farR = 5'h0A;
    // external codec lines flip each cycle so stale values never match
    always @(posedge sys_clk)
        farR <= ~farR;
    assign dualPinIn = (dualPinOe & dualPinOut) | (~dualPinOe & farR);
    assign externalCodecSelect = strapCfg[3];
    assign attachmentOrPairSelect = strapCfg[2];
    assign linkTestDisableN = strapCfg[1];
    assign lowSquelchSelect = strapCfg[0];
endmodule

// file: dv/nps_port_status_test.sv
// self-checking bench for the port status block
`timescale 1ns/1ps
module nps_port_status_test
    import nps_pkg::*;
;
    localparam int unsigned SL = 20;
    logic        sys_clk, rstn, wbCyc, wbStb, wbWe, good, lps, lpr, pes, prv;
    logic [3:0]  wbAdr, wbSel, cfg;
    logic [31:0] wbDat, wbQ, rd;
    logic        wbAck, codecEn, auiEn, pairEn, lpgEn, lchkEn, sqLow;
    logic        external_codec_select, aui, ltdN, lsq, polN, linkN;
    logic [2:0]  act, actN;
    logic [4:0]  pinIn, pinOut, pinOe, codecSig, macSig;
    int          error_cnt, compares;

    nps_port_status #(.STRETCH_LEN(SL), .NPINS(5)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(wbSel),
        .wb_dat_o(wbQ), .wb_ack_o(wbAck), .externalCodecSelect(external_codec_select),
        .attachmentOrPairSelect(aui), .linkTestDisableN(ltdN),
        .lowSquelchSelect(lsq), .codecEnable(codecEn), .auiPathEnable(auiEn),
        .pairPathEnable(pairEn), .linkPulseGenEnable(lpgEn),
        .linkCheckEnable(lchkEn), .squelchLowThreshold(sqLow),
        .dualPinIn(pinIn), .dualPinOut(pinOut), .dualPinOe(pinOe),
        .codecSideSig(codecSig), .macSideSig(macSig), .txActivity(act[0]),
        .rxActivity(act[1]), .collisionSeen(act[2]), .linkPulseSeen(lps),
        .linkPulseReversed(lpr), .packetEndSeen(pes), .packetReversed(prv),
        .linkIntegrityGood(good), .txActivityIndicatorN(actN[0]),
        .rxActivityIndicatorN(actN[1]), .collisionIndicatorN(actN[2]),
        .polarityFaultIndicatorN(polN), .linkGoodIndicatorN(linkN));
    nps_board_model board (.sys_clk(sys_clk), .strapCfg(cfg),
        .dualPinOut(pinOut), .dualPinOe(pinOe), .dualPinIn(pinIn),
        .externalCodecSelect(external_codec_select), .attachmentOrPairSelect(aui),
        .linkTestDisableN(ltdN), .lowSquelchSelect(lsq));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDat <= d;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            error_cnt++;
            end_of_test();
        end
        rd = wbQ;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic rst(input logic [3:0] c);
        @(posedge sys_clk);
        rstn <= 1'b0;
        cfg <= c;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic ev(input logic pkt, input logic rev);
        @(posedge sys_clk);
        lps <= !pkt;
        pes <= pkt;
        lpr <= rev;
        prv <= rev;
        @(posedge sys_clk);
        lps <= 1'b0;
        pes <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_straps();
        logic [3:0] c;
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            rst(c);
            chk(codecEn, !c[3]);
            chk(pinOe, {5{!c[3]}});
            chk(pinOut, codecSig);
            chk(macSig, c[3] ? pinIn : codecSig);
            chk(auiEn, !c[3] && c[2]);
            chk(pairEn, !c[3] && !c[2]);
            chk({lpgEn, lchkEn}, {2{!c[3] && !c[2] && c[1]}});
            chk(sqLow, c[0]);
            chk(linkN, c[2] || c[1]);
            wb(1'b0, STATUS_OFS, 32'h0);
            chk(rd[3:0], {c[0], c[1], c[2], c[3]});
        end
    endtask
    task automatic t_stretch();
        rst(4'h2);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge sys_clk);
            act[k] <= 1'b1;
            @(posedge sys_clk);
            act[k] <= 1'b0;
            #1;
            chk(actN[k], 1'b0);
            repeat (SL / 2) @(posedge sys_clk);
            act[k] <= 1'b1;
            @(posedge sys_clk);
            act[k] <= 1'b0;
            repeat (SL - 3) @(posedge sys_clk);
            #1;
            chk(actN[k], 1'b0);
            repeat (6) @(posedge sys_clk);
            #1;
            chk(actN, 3'h7);
        end
    endtask
    task automatic t_pol();
        rst(4'h2);
        repeat (6) ev(1'b0, 1'b1);
        chk(polN, 1'b1);
        ev(1'b0, 1'b1);
        chk(polN, 1'b0);
        ev(1'b0, 1'b0);
        chk(polN, 1'b1);
        repeat (2) ev(1'b1, 1'b1);
        chk(polN, 1'b1);
        ev(1'b1, 1'b1);
        chk(polN, 1'b0);
    endtask
    task automatic t_link();
        rst(4'h2);
        @(posedge sys_clk);
        good <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(linkN, 1'b0);
        @(posedge sys_clk);
        good <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(linkN, 1'b1);
        @(posedge sys_clk);
        good <= 1'b1;
        rst(4'h6);
        chk(linkN, 1'b1);
    endtask
    task automatic t_bus();
        rst(4'h2);
        wb(1'b1, 4'h8, 32'hFFFFFFFF);
        wb(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, CTRL_RST);
        wb(1'b1, CTRL_OFS, 32'h1);
        #1;
        chk({actN, polN, linkN}, 5'h00);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        wb(1'b1, CTRL_OFS, 32'h0);
        repeat (3) ev(1'b1, 1'b1);
        wb(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'h34);
        wb(1'b1, STATUS_OFS, 32'h20);
        wb(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'h14);
        @(posedge sys_clk);
        act <= 3'h7;
        @(posedge sys_clk);
        act <= 3'h0;
        wb(1'b0, STATUS_OFS, 32'h0);
        chk(rd[8:6], 3'h7);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        error_cnt = 0;
        compares = 0;
        {rstn, wbCyc, wbStb, wbWe, good, lps, lpr, pes, prv} = 9'h000;
        {wbAdr, cfg, act} = 11'h000;
        wbSel = 4'hF;
        wbDat = 32'h0;
        codecSig = 5'h0C;
        t_straps();
        t_stretch();
        t_pol();
        t_link();
        t_bus();
        end_of_test();
    end
endmodule

bind nps_port_status nps_port_status_chk #(.STRETCH_LEN(STRETCH_LEN)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .codecEnable(codecEnable),
    .auiPathEnable(auiPathEnable), .pairPathEnable(pairPathEnable),
    .linkPulseGenEnable(linkPulseGenEnable), .linkCheckEnable(linkCheckEnable),
    .dualPinOe(dualPinOe), .txActivity(txActivity), .rxActivity(rxActivity),
    .collisionSeen(collisionSeen), .linkPulseSeen(linkPulseSeen),
    .linkPulseReversed(linkPulseReversed), .packetEndSeen(packetEndSeen),
    .linkIntegrityGood(linkIntegrityGood),
    .txActivityIndicatorN(txActivityIndicatorN),
    .rxActivityIndicatorN(rxActivityIndicatorN),
    .collisionIndicatorN(collisionIndicatorN),
    .polarityFaultIndicatorN(polarityFaultIndicatorN),
    .linkGoodIndicatorN(linkGoodIndicatorN));
